// ### common/sli_pkg.sv
/*
 * status lamp indicator package: register map, reset values, blink timing, carriers.
 * assumes a 250 MHz hclk and a single AHB-Lite master.
 */
package sli_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    // control bit positions
    localparam int CTRL_TRIGGER = 0;
    localparam int CTRL_PROG_INT = 1;
    localparam int CTRL_TEST_PAT = 2;
    localparam int CTRL_AUTO_GE = 3;
    localparam int CTRL_EXT_SYNC = 4;
    localparam int CTRL_COMM_ERR = 5;
    localparam int CTRL_FW_ERR = 6;
    localparam int CTRL_WIDTH = 7;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // interrupt bit positions
    localparam int IRQ_PATTERN_CHG = 0;
    localparam int IRQ_ERROR_SET = 1;
    localparam int IRQ_BLINK_WRAP = 2;
    localparam int IRQ_BAD_ADDR = 3;
    // blink timing: half period of each rate
    localparam int CLK_MHZ = 250;
    localparam int SLOW_HALF_MS = 1000;
    localparam int FAST_HALF_MS = 250;
    localparam int SLOW_HALF_CYC = SLOW_HALF_MS * 1000 * CLK_MHZ;
    localparam int FAST_HALF_CYC = FAST_HALF_MS * 1000 * CLK_MHZ;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {SLI_STEADY, SLI_SLOW, SLI_FAST} sli_rate_e;
    typedef enum logic [1:0] {SLI_OFF, SLI_GREEN, SLI_YELLOW, SLI_RED} sli_colour_e;

    typedef struct packed {
        logic red;
        logic green;
    } sli_lamp_s;

    typedef struct packed {
        sli_colour_e colour;
        sli_rate_e rate;
    } sli_pattern_s;
endpackage

// ### rtl/sli_top.sv
/*
 * status lamp indicator: maps camera mode flags to a red/green lamp colour and blink rate.
 * assumes an AHB-Lite master on hclk; mode flags arrive from same-clock control logic
 * either as input ports or as software-set control bits (the two are or-ed).
 */
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - normal streaming with no special mode: lamp steady green
// - trigger mode: lamp blinks green at about 0.5 Hz
// - programmable integration (line, frame or both): green blinks at about 2 Hz
// - test pattern output: lamp steady yellow
// - auto gain/exposure mode: lamp blinks yellow at about 0.5 Hz
// - external sync slaving: lamp blinks yellow at about 2 Hz
// - link communication or firmware load error: lamp steady red
module sli_top #(
    parameter int SLOW_HALF = sli_pkg::SLOW_HALF_CYC,
    parameter int FAST_HALF = sli_pkg::FAST_HALF_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic trigger_mode,
    input wire logic prog_integration,
    input wire logic test_pattern,
    input wire logic auto_gain_exposure_mode,
    input wire logic ext_sync,
    input wire logic comm_error,
    input wire logic fw_load_error,
    output logic lamp_red,
    output logic lamp_green,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic [sli_pkg::CTRL_WIDTH-1:0] ctrl_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic [31:0] hrdata_r;
    logic irq_r;
    sli_pkg::sli_lamp_s lamp_r;

    wire addr_phase = hsel && hready && (htrans == sli_pkg::HTRANS_NONSEQ);
    wire ofs_known = (haddr[7:0] == sli_pkg::OFS_CTRL) || (haddr[7:0] == sli_pkg::OFS_STATUS) ||
                     (haddr[7:0] == sli_pkg::OFS_IRQ_STAT) || (haddr[7:0] == sli_pkg::OFS_IRQ_MASK);
    wire bad_addr = addr_phase && (!ofs_known || (haddr[31:8] != 24'h000000));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else if (clk_en) begin
            // writes land one edge later, when hwdata stands in the data phase
            wr_pend_r <= addr_phase && hwrite;
            if (addr_phase) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode flags and pattern selection
    wire f_trig = trigger_mode || ctrl_r[sli_pkg::CTRL_TRIGGER];
    wire f_prog = prog_integration || ctrl_r[sli_pkg::CTRL_PROG_INT];
    wire f_test = test_pattern || ctrl_r[sli_pkg::CTRL_TEST_PAT];
    wire f_auto = auto_gain_exposure_mode || ctrl_r[sli_pkg::CTRL_AUTO_GE];
    wire f_sync = ext_sync || ctrl_r[sli_pkg::CTRL_EXT_SYNC];
    wire f_err = comm_error || fw_load_error || ctrl_r[sli_pkg::CTRL_COMM_ERR] || ctrl_r[sli_pkg::CTRL_FW_ERR];

    // priority is undocumented: errors first, then yellow modes, then green modes,
    // so that a fault is never hidden behind an ordinary mode indication
    sli_pkg::sli_pattern_s pat;
    always_comb begin
        if (f_err) begin
            pat = '{sli_pkg::SLI_RED, sli_pkg::SLI_STEADY};
        end else if (f_test) begin
            pat = '{sli_pkg::SLI_YELLOW, sli_pkg::SLI_STEADY};
        end else if (f_sync) begin
            pat = '{sli_pkg::SLI_YELLOW, sli_pkg::SLI_FAST};
        end else if (f_auto) begin
            pat = '{sli_pkg::SLI_YELLOW, sli_pkg::SLI_SLOW};
        end else if (f_prog) begin
            pat = '{sli_pkg::SLI_GREEN, sli_pkg::SLI_FAST};
        end else if (f_trig) begin
            pat = '{sli_pkg::SLI_GREEN, sli_pkg::SLI_SLOW};
        end else begin
            pat = '{sli_pkg::SLI_GREEN, sli_pkg::SLI_STEADY};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // blink phase generators
    logic [31:0] slow_cnt_r;
    logic [31:0] fast_cnt_r;
    logic slow_ph_r;
    logic fast_ph_r;
    wire slow_wrap = (slow_cnt_r == 32'(SLOW_HALF - 1));
    wire fast_wrap = (fast_cnt_r == 32'(FAST_HALF - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_cnt_r <= 32'h00000000;
            fast_cnt_r <= 32'h00000000;
            slow_ph_r <= 1'b1;
            fast_ph_r <= 1'b1;
        end else if (clk_en) begin
            slow_cnt_r <= slow_wrap ? 32'h00000000 : slow_cnt_r + 32'h00000001;
            fast_cnt_r <= fast_wrap ? 32'h00000000 : fast_cnt_r + 32'h00000001;
            if (slow_wrap) begin
                slow_ph_r <= !slow_ph_r;
            end
            if (fast_wrap) begin
                fast_ph_r <= !fast_ph_r;
            end
        end
    end

    wire lit = (pat.rate == sli_pkg::SLI_STEADY) ? 1'b1 :
               (pat.rate == sli_pkg::SLI_SLOW) ? slow_ph_r : fast_ph_r;
    // yellow drives both elements from one lit term so they never drift apart
    wire red_nxt = lit && ((pat.colour == sli_pkg::SLI_RED) || (pat.colour == sli_pkg::SLI_YELLOW));
    wire green_nxt = lit && ((pat.colour == sli_pkg::SLI_GREEN) || (pat.colour == sli_pkg::SLI_YELLOW));

    sli_pkg::sli_pattern_s pat_r;
    logic err_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // registers, interrupts and outputs
    wire ctrl_we = clk_en && wr_pend_r && (addr_r == sli_pkg::OFS_CTRL);
    wire stat_we = clk_en && wr_pend_r && (addr_r == sli_pkg::OFS_IRQ_STAT);
    wire mask_we = clk_en && wr_pend_r && (addr_r == sli_pkg::OFS_IRQ_MASK);
    wire [3:0] ev = {bad_addr, slow_wrap, f_err && !err_d_r, pat != pat_r};
    // set wins over a simultaneous write-one clear
    wire [3:0] irq_stat_nxt = (irq_stat_r & ~(stat_we ? hwdata[3:0] : 4'h0)) | ev;

    wire [31:0] status_word = {26'h0, lamp_r.red, lamp_r.green, pat_r.rate, pat_r.colour};
    // read data is chosen in the address phase so that it stands through the whole data phase;
    // limitation: a read right behind a write to the same register returns the value before that write
    wire [7:0] rd_ofs = haddr[7:0];
    wire [31:0] rd_mux = (haddr[31:8] != 24'h000000) ? 32'h00000000 :
                         (rd_ofs == sli_pkg::OFS_CTRL) ? {25'h0000000, ctrl_r} :
                         (rd_ofs == sli_pkg::OFS_STATUS) ? status_word :
                         (rd_ofs == sli_pkg::OFS_IRQ_STAT) ? {28'h0000000, irq_stat_r} :
                         (rd_ofs == sli_pkg::OFS_IRQ_MASK) ? {28'h0000000, irq_mask_r} : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= sli_pkg::CTRL_RESET;
            irq_stat_r <= sli_pkg::IRQ_RESET;
            irq_mask_r <= sli_pkg::IRQ_RESET;
            pat_r <= '{sli_pkg::SLI_OFF, sli_pkg::SLI_STEADY};
            err_d_r <= 1'b0;
            lamp_r <= '0;
            irq_r <= 1'b0;
            hrdata_r <= 32'h00000000;
        end else if (clk_en) begin
            if (ctrl_we) begin
                ctrl_r <= hwdata[sli_pkg::CTRL_WIDTH-1:0];
            end
            if (mask_we) begin
                irq_mask_r <= hwdata[3:0];
            end
            irq_stat_r <= irq_stat_nxt;
            pat_r <= pat;
            err_d_r <= f_err;
            lamp_r <= '{red_nxt, green_nxt};
            irq_r <= |(irq_stat_nxt & (mask_we ? hwdata[3:0] : irq_mask_r));
            // hold the last read word between reads, as the bus allows
            hrdata_r <= (addr_phase && !hwrite) ? rd_mux : hrdata_r;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign lamp_red = lamp_r.red;
    assign lamp_green = lamp_r.green;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    wire quiet = !f_err && !f_test && !f_sync && !f_auto && !f_prog && !f_trig;

    property p_normal_green;
        @(posedge hclk) disable iff (!hresetn) (clk_en && quiet) |=> (lamp_green && !lamp_red);
    endproperty
    a_normal_green: assert property (p_normal_green) else $error("normal mode lamp not steady green");

    property p_trig_slow;
        @(posedge hclk) disable iff (!hresetn)
            (clk_en && f_trig && !f_prog && !f_auto && !f_sync && !f_test && !f_err) |=>
            (!lamp_red && lamp_green == $past(slow_ph_r));
    endproperty
    a_trig_slow: assert property (p_trig_slow) else $error("trigger mode not slow green blink");

    property p_prog_fast;
        @(posedge hclk) disable iff (!hresetn)
            (clk_en && f_prog && !f_auto && !f_sync && !f_test && !f_err) |=>
            (!lamp_red && lamp_green == $past(fast_ph_r));
    endproperty
    a_prog_fast: assert property (p_prog_fast) else $error("integration mode not fast green blink");

    property p_test_yellow;
        @(posedge hclk) disable iff (!hresetn) (clk_en && f_test && !f_err) |=> (lamp_red && lamp_green);
    endproperty
    a_test_yellow: assert property (p_test_yellow) else $error("test mode lamp not steady yellow");

    property p_auto_slow;
        @(posedge hclk) disable iff (!hresetn) (clk_en && f_auto && !f_sync && !f_test && !f_err) |=>
            (lamp_red == $past(slow_ph_r) && lamp_green == $past(slow_ph_r));
    endproperty
    a_auto_slow: assert property (p_auto_slow) else $error("auto gain mode not slow yellow blink");

    property p_sync_fast;
        @(posedge hclk) disable iff (!hresetn) (clk_en && f_sync && !f_test && !f_err) |=>
            (lamp_red == $past(fast_ph_r) && lamp_green == $past(fast_ph_r));
    endproperty
    a_sync_fast: assert property (p_sync_fast) else $error("external sync mode not fast yellow blink");

    property p_err_red;
        @(posedge hclk) disable iff (!hresetn) (clk_en && f_err) |=> (lamp_red && !lamp_green);
    endproperty
    a_err_red: assert property (p_err_red) else $error("error not shown as steady red");

    property p_yellow_pair;
        @(posedge hclk) disable iff (!hresetn) (pat_r.colour == sli_pkg::SLI_YELLOW) |-> (lamp_red == lamp_green);
    endproperty
    a_yellow_pair: assert property (p_yellow_pair) else $error("yellow elements out of step");

    ////////////////////////////////////////////////////////////////////////////
    // blink timing, register and bus checks

    // the counters must never run past their half period, or a rate would stretch
    property p_slow_bound;
        @(posedge hclk) disable iff (!hresetn)
            1'b1 |-> (slow_cnt_r < 32'(SLOW_HALF));
    endproperty
    a_slow_bound: assert property (p_slow_bound) else $error("slow blink counter out of range");

    property p_fast_bound;
        @(posedge hclk) disable iff (!hresetn)
            1'b1 |-> (fast_cnt_r < 32'(FAST_HALF));
    endproperty
    a_fast_bound: assert property (p_fast_bound) else $error("fast blink counter out of range");

    // a phase may only turn over at the end of its half period
    property p_slow_hold;
        @(posedge hclk) disable iff (!hresetn)
            (clk_en && !slow_wrap) |=> $stable(slow_ph_r);
    endproperty
    a_slow_hold: assert property (p_slow_hold) else $error("slow phase flipped early");

    property p_fast_hold;
        @(posedge hclk) disable iff (!hresetn)
            (clk_en && !fast_wrap) |=> $stable(fast_ph_r);
    endproperty
    a_fast_hold: assert property (p_fast_hold) else $error("fast phase flipped early");

    // set wins: every event of a cycle must be visible in the status one edge later
    property p_stat_sticky;
        @(posedge hclk) disable iff (!hresetn)
            clk_en |=> ((irq_stat_r & $past(ev)) == $past(ev));
    endproperty
    a_stat_sticky: assert property (p_stat_sticky) else $error("status event lost");

    property p_err_event;
        @(posedge hclk) disable iff (!hresetn)
            (clk_en && f_err && !err_d_r) |=> irq_stat_r[sli_pkg::IRQ_ERROR_SET];
    endproperty
    a_err_event: assert property (p_err_event) else $error("error rise not flagged");

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
            1'b1 |-> (irq == |(irq_stat_r & irq_mask_r));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq line not the or of unmasked status");

    property p_ctrl_write;
        @(posedge hclk) disable iff (!hresetn)
            ctrl_we |=> (ctrl_r == $past(hwdata[sli_pkg::CTRL_WIDTH-1:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write did not land");

    property p_unmapped_zero;
        @(posedge hclk) disable iff (!hresetn)
            (clk_en && bad_addr && !hwrite) |=> (hrdata == 32'h00000000);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_bus_okay;
        @(posedge hclk) disable iff (!hresetn)
            1'b1 |-> (hreadyout && !hresp);
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus response not ready and okay");

    // a low enable must freeze every visible output
    property p_freeze;
        @(posedge hclk) disable iff (!hresetn)
            !clk_en |=> ($stable(lamp_red) && $stable(lamp_green) && $stable(irq) && $stable(hrdata));
    endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while enable low");

    c_yellow_slow: cover property (@(posedge hclk) disable iff (!hresetn)
        (pat_r.colour == sli_pkg::SLI_YELLOW) && (pat_r.rate == sli_pkg::SLI_SLOW));
    c_freeze: cover property (@(posedge hclk) disable iff (!hresetn) !clk_en ##1 !clk_en);
    c_err: cover property (@(posedge hclk) disable iff (!hresetn) f_err ##1 lamp_red);
    c_fast_toggle: cover property (@(posedge hclk) disable iff (!hresetn) f_sync && fast_wrap);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) !irq ##1 irq);
endmodule

// ### verification/sli_lamp_model.sv
/*
 * bicolour lamp as a watcher sees it: last run lengths, flips and colour splits.
 * assumes active high lamp lines that are sampled on hclk.
 */
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module sli_lamp_model (
    input wire logic hclk,
    input wire logic lamp_red,
    input wire logic lamp_green,
    output int g_run,
    output int r_run,
    output int flips,
    output int apart
);
    logic red_r = 1'b0;
    logic green_r = 1'b0;
    int g_cnt = 0;
    int r_cnt = 0;

    // a run is the number of samples between two changes of one element
    always @(posedge hclk) begin
        if (lamp_green !== green_r) begin
            g_run <= g_cnt;
            g_cnt <= 1;
        end else begin
            g_cnt <= g_cnt + 1;
        end
        if (lamp_red !== red_r) begin
            r_run <= r_cnt;
            r_cnt <= 1;
        end else begin
            r_cnt <= r_cnt + 1;
        end
        if ((lamp_green !== green_r) || (lamp_red !== red_r)) begin
            flips <= flips + 1;
        end
        // yellow must never show as one element alone
        if (lamp_red !== lamp_green) begin
            apart <= apart + 1;
        end
        green_r <= lamp_green;
        red_r <= lamp_red;
    end
endmodule

// ### verification/sli_top_test.sv
/*
 * self-checking bench for the status lamp indicator: modes, registers, interrupt.
 * assumes short blink parameters and a zero-wait AHB-Lite slave.
 */
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module sli_top_test;
    localparam int S = 8;
    localparam int F = 2;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [6:0] flags = 7'h00;
    logic [31:0] rd;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, lamp_red, lamp_green, irq;
    int g_run, r_run, flips, apart;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    sli_top #(.SLOW_HALF(S), .FAST_HALF(F)) sli_top_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .trigger_mode(flags[0]), .prog_integration(flags[1]), .test_pattern(flags[2]),
        .auto_gain_exposure_mode(flags[3]), .ext_sync(flags[4]), .comm_error(flags[5]),
        .fw_load_error(flags[6]), .lamp_red(lamp_red), .lamp_green(lamp_green), .irq(irq));
    sli_lamp_model sli_lamp_model_inst (.hclk(hclk), .lamp_red(lamp_red), .lamp_green(lamp_green),
        .g_run(g_run), .r_run(r_run), .flips(flips), .apart(apart));

    initial begin
        forever #2 hclk = ~hclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // a hung handshake never returns, so the cycle ceiling ends the run
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= sli_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask

    // half of zero means a steady pattern
    task automatic mode(input int bitn, input logic r, input logic g, input int half);
        int f0;
        int a0;
        @(posedge hclk);
        flags <= (bitn < 0) ? 7'h00 : 7'(1 << bitn);
        repeat (3) @(posedge hclk);
        f0 = flips;
        a0 = apart;
        repeat (3 * ((half == 0) ? S : half) + 2) @(posedge hclk);
        if (half == 0) begin
            check("steady flips", flips, f0);
            check("lamp red", lamp_red, r);
            check("lamp green", lamp_green, g);
        end else begin
            if (g) check("green run", g_run, half);
            if (r) check("red run", r_run, half);
            if (!r) check("lamp red", lamp_red, 1'b0);
        end
        if (r && g) check("colour split", apart, a0);
    endtask

    task automatic t_modes();
        mode(-1, 1'b0, 1'b1, 0);
        mode(sli_pkg::CTRL_TRIGGER, 1'b0, 1'b1, S);
        mode(sli_pkg::CTRL_PROG_INT, 1'b0, 1'b1, F);
        mode(sli_pkg::CTRL_TEST_PAT, 1'b1, 1'b1, 0);
        mode(sli_pkg::CTRL_AUTO_GE, 1'b1, 1'b1, S);
        mode(sli_pkg::CTRL_EXT_SYNC, 1'b1, 1'b1, F);
        mode(sli_pkg::CTRL_COMM_ERR, 1'b1, 1'b0, 0);
        mode(sli_pkg::CTRL_FW_ERR, 1'b1, 1'b0, 0);
        mode(-1, 1'b0, 1'b1, 0);
        $display("test modes done");
    endtask

    task automatic t_regs();
        bus(1'b0, sli_pkg::OFS_CTRL, 32'h0, rd);
        check("ctrl reset", rd, 32'h0);
        bus(1'b0, sli_pkg::OFS_IRQ_MASK, 32'h0, rd);
        check("mask reset", rd, 32'h0);
        bus(1'b1, sli_pkg::OFS_CTRL, 32'h4, rd);
        bus(1'b0, sli_pkg::OFS_CTRL, 32'h0, rd);
        check("ctrl readback", rd, 32'h4);
        repeat (2) @(posedge hclk);
        check("lamp both", {lamp_red, lamp_green}, 2'h3);
        bus(1'b0, sli_pkg::OFS_STATUS, 32'h0, rd);
        check("status yellow", rd, 32'h32);
        bus(1'b1, sli_pkg::OFS_CTRL, 32'h0, rd);
        $display("test regs done");
    endtask

    task automatic t_irq();
        bus(1'b1, sli_pkg::OFS_IRQ_STAT, 32'hf, rd);
        bus(1'b1, sli_pkg::OFS_IRQ_MASK, 32'h1, rd);
        repeat (2) @(posedge hclk);
        check("irq idle", irq, 1'b0);
        flags <= 7'h01;
        repeat (4) @(posedge hclk);
        check("irq raised", irq, 1'b1);
        bus(1'b1, sli_pkg::OFS_IRQ_STAT, 32'h1, rd);
        repeat (2) @(posedge hclk);
        check("irq cleared", irq, 1'b0);
        bus(1'b1, sli_pkg::OFS_IRQ_MASK, 32'h0, rd);
        flags <= 7'h00;
        repeat (4) @(posedge hclk);
        check("irq masked", irq, 1'b0);
        bus(1'b0, 8'h10, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        bus(1'b0, sli_pkg::OFS_IRQ_STAT, 32'h0, rd);
        check("sticky bits", rd[3] & rd[0], 1'b1);
        check("wrap sticky", rd[2], 1'b1);
        $display("test irq done");
    endtask

    // a low enable must hold a blinking lamp where it is
    task automatic t_freeze();
        int f0;
        flags <= 7'h01;
        repeat (4) @(posedge hclk);
        clk_en <= 1'b0;
        repeat (2) @(posedge hclk);
        f0 = flips;
        repeat (3 * S) @(posedge hclk);
        check("frozen lamp", flips, f0);
        clk_en <= 1'b1;
        flags <= 7'h00;
        repeat (2) @(posedge hclk);
        $display("test freeze done");
    endtask

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_modes();
        t_irq();
        t_freeze();
        complete_run();
    end
endmodule
